/* File: power_mgr_model.sv */
// power manager stand-in: enters low power modes, leaves them on wake
`timescale 1ns/1ns
`default_nettype none
module power_mgr_model
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [2:0] enter_i,
  input  wire logic       wake_i,
  input  wire logic       vreg_wake_i,
  output var  logic       sleep_o,
  output var  logic       deep_sleep_o,
  output var  logic       hibernate_o
);
  // mode is a level; either wake request puts the core back to active, but an enter request in the same cycle wins
  always @(posedge clk_i)
  begin
    if (rst_i)
      {hibernate_o, deep_sleep_o, sleep_o} <= 3'h0;
    else if (enter_i != 3'h0)
      {hibernate_o, deep_sleep_o, sleep_o} <= enter_i;
    else if (wake_i || vreg_wake_i)
      {hibernate_o, deep_sleep_o, sleep_o} <= 3'h0;
  end
endmodule
`default_nettype wire

/* File: rtc_core.v */
// watch calendar clock: counters, alarms, stopwatch, interrupts, wake-up, wishbone slave
//
// The Wishbone interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "rtc_defs.vh"
module rtc_core
#(
  parameter [`RTC_PRE_W:0] PRESCALE_DIV = `RTC_PRESCALE_DIV
)
(
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        xtal_i,
  input  wire [7:0]  adr_i,
  input  wire [31:0] dat_i,
  input  wire [3:0]  sel_i,
  input  wire        we_i,
  input  wire        cyc_i,
  input  wire        stb_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  input  wire        sleep_i,
  input  wire        deep_sleep_i,
  input  wire        hibernate_i,
  output reg         irq_o,
  output reg         wake_o,
  output reg         vreg_wake_o
);
  wire                  xtal_rise;
  wire                  tick;
  reg                   tick_d1_q;
  reg  [5:0]            sec_q;
  reg  [5:0]            min_q;
  reg  [4:0]            hour_q;
  reg  [14:0]           day_q;
  reg                   sw_en_q;
  reg  [`RTC_SW_W-1:0]  sw_q;
  reg  [31:0]           alm1_q;
  reg  [31:0]           alm2_q;
  reg  [`RTC_EV_NUM-1:0] mask_q;
  reg  [`RTC_EV_NUM-1:0] wake_en_q;
  reg  [`RTC_EV_NUM-1:0] stat_q;
  reg  [`RTC_EV_NUM-1:0] evt;
  reg  [31:0]           rd_d;
  wire [31:0]           time_word;
  wire                  req;
  wire                  wr;
  wire                  rd;
  wire                  time_wr;
  wire                  stat_rd;
  wire                  sec_wrap;
  wire                  min_wrap;
  wire                  hour_wrap;
  wire                  day_wrap;
  wire                  tod_match1;
  wire                  tod_match2;
  wire                  day_match2;
  wire                  sw_under;
  wire [31:0]           sw_wr_word;
  wire                  wake_pend;

  // merge byte lanes of a write into the old word
  function [31:0] merge;
    input [31:0] old_w;
    input [31:0] new_w;
    input [3:0]  sel;
    integer      b;
    begin
      merge = old_w;
      for (b = 0; b < 4; b = b + 1)
      begin
        if (sel[b])
        begin
          merge[b*8 +: 8] = new_w[b*8 +: 8];
        end
      end
    end
  endfunction

  // crystal pin crossing and seconds prescaler
  rtc_xtal_sync u_sync
  (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .xtal_i (xtal_i),
    .rise_o (xtal_rise)
  );

  rtc_prescaler
  #(
    .DIV (PRESCALE_DIV)
  )
  u_pre
  (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .clr_i  (time_wr),
    .edge_i (xtal_rise),
    .tick_o (tick)
  );

  // bus request qualifiers; one access is taken per handshake
  assign req     = cyc_i & stb_i & ~ack_o;
  assign wr      = req & we_i;
  assign rd      = req & ~we_i;
  assign time_wr = wr & (adr_i == `RTC_TIME_OFS);
  assign stat_rd = rd & (adr_i == `RTC_STAT_OFS);

  assign time_word = {day_q, hour_q, min_q, sec_q};

  // terminal detection for the cascade
  assign sec_wrap  = (sec_q == `RTC_SEC_LAST);
  assign min_wrap  = sec_wrap & (min_q == `RTC_MIN_LAST);
  assign hour_wrap = min_wrap & (hour_q == `RTC_HOUR_LAST);
  assign day_wrap  = hour_wrap & (day_q == `RTC_DAY_LAST);

  // cascaded time counters; a software time write wins over a tick
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      {day_q, hour_q, min_q, sec_q} <= `RTC_TIME_RST;
    end
    else if (time_wr)
    begin
      {day_q, hour_q, min_q, sec_q} <= merge(time_word, dat_i, sel_i); // fields in word order
    end
    else if (tick)
    begin
      sec_q <= sec_wrap ? 6'h00 : sec_q + 6'h01;
      if (sec_wrap)
      begin
        min_q <= (min_q == `RTC_MIN_LAST) ? 6'h00 : min_q + 6'h01;
      end
      if (min_wrap)
      begin
        hour_q <= (hour_q == `RTC_HOUR_LAST) ? 5'h00 : hour_q + 5'h01;
      end
      if (hour_wrap)
      begin
        day_q <= day_wrap ? 15'h0000 : day_q + 15'h0001;
      end
    end
  end

  // alarms compare one cycle after the tick, against the fresh time
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tick_d1_q <= 1'b0;
    end
    else
    begin
      tick_d1_q <= tick & ~time_wr;
    end
  end

  assign tod_match1 = (alm1_q[`RTC_HOUR_MSB:`RTC_SEC_LSB]
                       == time_word[`RTC_HOUR_MSB:`RTC_SEC_LSB]);
  assign tod_match2 = (alm2_q[`RTC_HOUR_MSB:`RTC_SEC_LSB]
                       == time_word[`RTC_HOUR_MSB:`RTC_SEC_LSB]);
  assign day_match2 = (alm2_q[`RTC_DAY_MSB:`RTC_DAY_LSB] == day_q);

  // stopwatch: reloads on write, decrements each second while enabled
  assign sw_under = tick & sw_en_q & (sw_q == {`RTC_SW_W{1'b0}});
  assign sw_wr_word = merge({16'h0000, sw_q}, dat_i, sel_i);

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sw_q <= `RTC_SW_RST;
    end
    else if (wr && adr_i == `RTC_SWATCH_OFS)
    begin
      sw_q <= sw_wr_word[`RTC_SW_W-1:0];
    end
    else if (tick && sw_en_q)
    begin
      sw_q <= sw_under ? `RTC_SW_WRAP : sw_q - 16'h0001;
    end
  end

  // raw events of one cycle each; a time write suppresses a colliding tick for all but the stopwatch event
  always @*
  begin
    evt                = {`RTC_EV_NUM{1'b0}};
    evt[`RTC_EV_SEC]   = tick & ~time_wr;
    evt[`RTC_EV_MIN]   = tick & ~time_wr & sec_wrap;
    evt[`RTC_EV_HOUR]  = tick & ~time_wr & min_wrap;
    evt[`RTC_EV_DAY]   = tick & ~time_wr & hour_wrap;
    evt[`RTC_EV_ALM1]  = tick_d1_q & tod_match1;
    evt[`RTC_EV_ALM2]  = tick_d1_q & tod_match2 & day_match2;
    evt[`RTC_EV_SW]    = sw_under;
  end

  // sticky pending bits: set wins over the clear by a status read
  genvar gi;
  generate
    for (gi = 0; gi < `RTC_EV_NUM; gi = gi + 1)
    begin : g_stat
      always @(posedge clk_i)
      begin
        if (rst_i)
        begin
          stat_q[gi] <= 1'b0;
        end
        else if (evt[gi])
        begin
          stat_q[gi] <= 1'b1;
        end
        else if (stat_rd)
        begin
          stat_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // software-written control, alarm, mask and wake-enable registers
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sw_en_q   <= `RTC_CTRL_RST;
      alm1_q    <= `RTC_ALM_RST;
      alm2_q    <= `RTC_ALM_RST;
      mask_q    <= `RTC_MASK_RST;
      wake_en_q <= `RTC_WAKE_RST;
    end
    else if (wr)
    begin
      case (adr_i)
        `RTC_CTRL_OFS:
        begin
          if (sel_i[0])
          begin
            sw_en_q <= dat_i[`RTC_CTRL_SW_EN];
          end
        end
        `RTC_ALM1_OFS: alm1_q <= merge(alm1_q, dat_i, sel_i);
        `RTC_ALM2_OFS: alm2_q <= merge(alm2_q, dat_i, sel_i);
        `RTC_MASK_OFS:
        begin
          if (sel_i[0])
          begin
            mask_q <= dat_i[`RTC_EV_NUM-1:0];
          end
        end
        `RTC_WAKE_OFS:
        begin
          if (sel_i[0])
          begin
            wake_en_q <= dat_i[`RTC_EV_NUM-1:0];
          end
        end
        default:       sw_en_q <= sw_en_q;
      endcase
    end
  end

  // read mux; unmapped offsets answer with zero
  always @*
  begin
    rd_d = 32'h0000_0000;
    case (adr_i)
      `RTC_TIME_OFS:   rd_d = time_word;
      `RTC_CTRL_OFS:   rd_d[`RTC_CTRL_SW_EN] = sw_en_q;
      `RTC_STAT_OFS:   rd_d[`RTC_EV_NUM-1:0] = stat_q;
      `RTC_MASK_OFS:   rd_d[`RTC_EV_NUM-1:0] = mask_q;
      `RTC_ALM1_OFS:   rd_d = alm1_q;
      `RTC_ALM2_OFS:   rd_d = alm2_q;
      `RTC_SWATCH_OFS: rd_d[`RTC_SW_W-1:0] = sw_q;
      `RTC_WAKE_OFS:   rd_d[`RTC_EV_NUM-1:0] = wake_en_q;
      default:         rd_d = 32'h0000_0000;
    endcase
  end

  // one wait state: ack the cycle after the request, drop it the next
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack_o <= req;
      if (rd)
      begin
        dat_o <= rd_d;
      end
    end
  end

  // wake sources use their own enables, independent of the irq mask
  assign wake_pend = |(stat_q & wake_en_q);

  // interrupt and wake outputs, all registered
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_o       <= 1'b0;
      wake_o      <= 1'b0;
      vreg_wake_o <= 1'b0;
    end
    else
    begin
      irq_o       <= |(stat_q & mask_q);
      wake_o      <= wake_pend & (sleep_i | deep_sleep_i);
      vreg_wake_o <= wake_pend & (deep_sleep_i | hibernate_i);
    end
  end

  // counting never waits on the bus, so deep sleep leaves the time intact;
  // the block has no master port and so makes no accesses of its own
endmodule
`default_nettype wire

/* File: rtc_core_checker.sv */
// port-level assertions for the watch calendar clock
`timescale 1ns/1ns
`default_nettype none
module rtc_core_checker
#(
  parameter [16:0] PRESCALE_DIV = 17'd32768
)
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        xtal_i,
  input wire logic [7:0]  adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0]  sel_i,
  input wire logic        we_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        sleep_i,
  input wire logic        deep_sleep_i,
  input wire logic        hibernate_i,
  input wire logic        irq_o,
  input wire logic        wake_o,
  input wire logic        vreg_wake_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // bus request present, answered or not
  wire req = cyc_i && stb_i;
  property p_ack_lat;
    req && !ack_o |=> ack_o;
  endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("ack late");
  property p_ack_pulse;
    ack_o |=> !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  // own disable: this one is about reset itself
  property p_rst_quiet;
    @(posedge clk_i) disable iff (1'b0)
    rst_i |=> !ack_o && !irq_o && !wake_o && !vreg_wake_o && dat_o == 32'h0;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs live in reset");
  property p_dat_hold;
    !(req && !we_i && !ack_o) |=> $stable(dat_o);
  endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
  // a read clears status one edge on and irq the edge after, so skip cycles near any access
  property p_irq_hold;
    irq_o && !req && !$past(req) |=> irq_o;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
  property p_wake_mode;
    wake_o |-> $past(sleep_i || deep_sleep_i);
  endproperty
  a_wake_mode: assert property (p_wake_mode) else $error("wake while awake");
  property p_vreg_mode;
    vreg_wake_o |-> $past(deep_sleep_i || hibernate_i);
  endproperty
  a_vreg_mode: assert property (p_vreg_mode) else $error("vreg wake stray");
  property p_deep_both;
    wake_o && $past(deep_sleep_i) |-> vreg_wake_o;
  endproperty
  a_deep_both: assert property (p_deep_both) else $error("deep wake split");
  c_irq: cover property ($rose(irq_o));
  c_wake: cover property ($rose(wake_o));
  c_vreg: cover property ($rose(vreg_wake_o));
endmodule
bind rtc_core rtc_core_checker #(.PRESCALE_DIV(PRESCALE_DIV)) chk (.clk_i(clk_i),
  .rst_i(rst_i), .xtal_i(xtal_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
  .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
  .sleep_i(sleep_i), .deep_sleep_i(deep_sleep_i), .hibernate_i(hibernate_i),
  .irq_o(irq_o), .wake_o(wake_o), .vreg_wake_o(vreg_wake_o));
`default_nettype wire

/* File: rtc_defs.vh */
// register map, field layout, reset values and timing counts of the watch calendar clock
`ifndef RTC_DEFS_VH
`define RTC_DEFS_VH

// register byte offsets
`define RTC_TIME_OFS      8'h00
`define RTC_CTRL_OFS      8'h04
`define RTC_STAT_OFS      8'h08
`define RTC_MASK_OFS      8'h0c
`define RTC_ALM1_OFS      8'h10
`define RTC_ALM2_OFS      8'h14
`define RTC_SWATCH_OFS    8'h18
`define RTC_WAKE_OFS      8'h1c

// time word layout: seconds, minutes, hours, days
`define RTC_SEC_LSB       0
`define RTC_SEC_MSB       5
`define RTC_MIN_LSB       6
`define RTC_MIN_MSB       11
`define RTC_HOUR_LSB      12
`define RTC_HOUR_MSB      16
`define RTC_DAY_LSB       17
`define RTC_DAY_MSB       31

// counter moduli, terminal values
`define RTC_SEC_LAST      6'h3b
`define RTC_MIN_LAST      6'h3b
`define RTC_HOUR_LAST     5'h17
`define RTC_DAY_LAST      15'h7fff

// control bits
`define RTC_CTRL_SW_EN    0

// event / status / mask / wake bit positions
`define RTC_EV_SEC        0
`define RTC_EV_MIN        1
`define RTC_EV_HOUR       2
`define RTC_EV_DAY        3
`define RTC_EV_ALM1       4
`define RTC_EV_ALM2       5
`define RTC_EV_SW         6
`define RTC_EV_NUM        7

// stopwatch width and underflow reload
`define RTC_SW_W          16
`define RTC_SW_WRAP       16'hffff

// reset values
`define RTC_TIME_RST      32'h0000_0000
`define RTC_CTRL_RST      1'b0
`define RTC_MASK_RST      7'h00
`define RTC_WAKE_RST      7'h00
`define RTC_ALM_RST       32'h0000_0000
`define RTC_SW_RST        16'h0000

// timing: crystal rate and tick rate, prescale ratio derived
`define RTC_XTAL_HZ       32768
`define RTC_TICK_HZ       1
`define RTC_PRESCALE_DIV  (`RTC_XTAL_HZ / `RTC_TICK_HZ)
`define RTC_PRE_W         16

`endif

/* File: rtc_prescaler.v */
// divides agreed crystal edges down to a one-cycle seconds tick
`timescale 1ns/1ns
`default_nettype none
`include "rtc_defs.vh"
module rtc_prescaler
#(
  parameter [`RTC_PRE_W:0] DIV = `RTC_PRESCALE_DIV
)
(
  input  wire clk_i,
  input  wire rst_i,
  input  wire clr_i,
  input  wire edge_i,
  output reg  tick_o
);
  reg [`RTC_PRE_W-1:0] cnt_q;

  // clear restarts a full second so a time write lands on a fresh boundary
  always @(posedge clk_i)
  begin
    if (rst_i || clr_i)
    begin
      cnt_q  <= {`RTC_PRE_W{1'b0}};
      tick_o <= 1'b0;
    end
    else
    begin
      tick_o <= 1'b0;
      if (edge_i)
      begin
        if ({1'b0, cnt_q} == DIV - 1'b1)
        begin
          cnt_q  <= {`RTC_PRE_W{1'b0}};
          tick_o <= 1'b1;
        end
        else
        begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: rtc_xtal_sync.v */
// three-stage synchroniser for the crystal pin with agreed rising-edge pulse
`timescale 1ns/1ns
`default_nettype none
module rtc_xtal_sync
(
  input  wire clk_i,
  input  wire rst_i,
  input  wire xtal_i,
  output reg  rise_o
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  reg lvl_q;

  // first stage feeds only the second; level moves once stages two and three agree
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_q   <= 1'b0;
      s2_q   <= 1'b0;
      s3_q   <= 1'b0;
      lvl_q  <= 1'b0;
      rise_o <= 1'b0;
    end
    else
    begin
      s1_q   <= xtal_i;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      rise_o <= 1'b0;
      if (s2_q == s3_q)
      begin
        lvl_q  <= s3_q;
        rise_o <= s3_q & ~lvl_q;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb_rtc_core.sv */
// self-checking bench for the watch calendar clock
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fails++; \
  $display("Error t=%0t got=%h exp=%h", $time, g, e); end end
module tb_rtc_core;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        xtal_i = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0;
  logic [3:0]  sel_i = 4'h0;
  logic        we_i = 1'b0;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic [2:0]  enter = 3'h0;
  wire  [31:0] dat_o;
  wire         ack_o, irq_o, wake_o, vreg_wake_o, sleep_i, deep_sleep_i, hibernate_i;
  logic [63:0] exp_q[$];
  logic [31:0] rnd = 32'hbbc5;
  int          fails = 0;
  int          cmp_count = 0;
  initial
  begin
    forever #2 clk_i = ~clk_i;
  end
  // crystal stand-in; four of its rising edges make one second here
  initial
  begin
    forever begin repeat (8) @(posedge clk_i); xtal_i <= ~xtal_i; end
  end
  rtc_core #(.PRESCALE_DIV(17'd4)) dut (.clk_i(clk_i), .rst_i(rst_i), .xtal_i(xtal_i),
    .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .dat_o(dat_o), .ack_o(ack_o), .sleep_i(sleep_i), .deep_sleep_i(deep_sleep_i),
    .hibernate_i(hibernate_i), .irq_o(irq_o), .wake_o(wake_o), .vreg_wake_o(vreg_wake_o));
  power_mgr_model pm (.clk_i(clk_i), .rst_i(rst_i), .enter_i(enter), .wake_i(wake_o),
    .vreg_wake_i(vreg_wake_o), .sleep_o(sleep_i), .deep_sleep_o(deep_sleep_i),
    .hibernate_o(hibernate_i));
  // read data taken at the ack edge against the oldest note
  always @(posedge clk_i)
    if (ack_o === 1'b1 && we_i === 1'b0 && exp_q.size() > 0)
    begin : mon
      logic [63:0] e;
      e = exp_q.pop_front();
      `CHK(dat_o & e[31:0], e[63:32])
    end
  task automatic finish_test;
    if (fails == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // one classic cycle; a read notes expected data under a compare mask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, e, m);
    int n;
    if (!w) exp_q.push_back({e, m});
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, 4'hf};
    n = 0;
    do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 100);
    if (n >= 100) begin fails++; finish_test(); end
    {cyc_i, stb_i} <= 2'b00;
    @(posedge clk_i);
  endtask
  // bounded wait on irq (s=0) or either wake output
  task automatic wt(input int s);
    int n;
    n = 0;
    while ((s == 0 ? irq_o : (wake_o | vreg_wake_o)) !== 1'b1 && n < 2000)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 2000) begin fails++; finish_test(); end
  endtask
  // noise targets, their kept bits, and the wake pattern of each low power mode
  logic [7:0]  ofs [5] = '{8'h0c, 8'h14, 8'h18, 8'h1c, 8'h04};
  logic [31:0] msk [5] = '{32'h7f, 32'hffffffff, 32'hffff, 32'h7f, 32'h1};
  logic [1:0]  wk  [3] = '{2'b10, 2'b11, 2'b01};
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // reset values, then an unmapped offset
    for (int i = 0; i <= 32; i += 4) bus(i[7:0], 0, 0, 0, 32'hffffffff);
    // noise through mask, alarm 2, stopwatch, wake-enable and control, read back only the kept bits
    foreach (ofs[i])
    begin
      rnd = lfsr(rnd);
      bus(ofs[i], 1, rnd, 0, 0);
      bus(ofs[i], 0, 0, rnd & msk[i], 32'hffffffff);
    end
    bus(8'h20, 1, rnd, 0, 0);
    bus(8'h20, 0, 0, 0, 32'hffffffff);
    bus(8'h04, 1, 0, 0, 0);
    // every unit at its last value: one tick carries all the way round
    bus(8'h0c, 1, 32'hf, 0, 0);
    bus(8'h00, 1, 32'hffff7efb, 0, 0);
    bus(8'h08, 0, 0, 0, 0);
    // a time write restarts the second: no tick before three more crystal periods
    repeat (40) @(posedge clk_i);
    `CHK(irq_o, 1'b0)
    wt(0);
    bus(8'h00, 0, 0, 0, 32'hffffffff);
    bus(8'h08, 0, 0, 32'hf, 32'hf);
    `CHK(irq_o, 1'b0)
    // first alarm ignores its day field, second matches day 0
    bus(8'h10, 1, 32'h000a0002, 0, 0);
    bus(8'h14, 1, 32'h3, 0, 0);
    bus(8'h0c, 1, 32'h30, 0, 0);
    bus(8'h08, 0, 0, 0, 0);
    wt(0);
    bus(8'h08, 0, 0, 32'h10, 32'h30);
    wt(0);
    bus(8'h08, 0, 0, 32'h20, 32'h30);
    bus(8'h00, 0, 0, 32'h3, 32'hffffffff);
    // stopwatch from one: zero after a second, underflow the next
    bus(8'h0c, 1, 32'h40, 0, 0);
    bus(8'h18, 1, 32'h1, 0, 0);
    bus(8'h04, 1, 32'h1, 0, 0);
    bus(8'h08, 0, 0, 0, 0);
    wt(0);
    bus(8'h08, 0, 0, 32'h40, 32'h40);
    bus(8'h18, 0, 0, 32'hffff, 32'hffffffff);
    bus(8'h04, 1, 32'h0, 0, 0);
    // each low power mode woken by the seconds event; no access meanwhile
    bus(8'h0c, 1, 32'h0, 0, 0);
    bus(8'h1c, 1, 32'h1, 0, 0);
    for (int i = 0; i < 3; i++)
    begin
      bus(8'h08, 0, 0, 0, 0);
      enter <= 3'(1 << i);
      @(posedge clk_i);
      enter <= 3'h0;
      wt(1);
      `CHK({wake_o, vreg_wake_o}, wk[i])
      repeat (3) @(posedge clk_i);
      `CHK({hibernate_i, deep_sleep_i, sleep_i}, 3'h0)
    end
    finish_test();
  end
endmodule
`default_nettype wire
